// [logic/selftest_pkg.sv]
// What this block does
// - Started fill writes every buffer byte and sums each written byte.
// - Finished fill loads its checksum into the self-test checksum pair.
// - Four fill kinds exist: random, address, rotating pattern and reserved, which writes zero bytes.
// - Port select swaps the SRAM ports of self-test and DMA engines.
// - DMA reads one byte per cycle, the same rate as the fill.
// - Clearing both go bits and test enable cancels a test at once.
// - Self-test go clears itself when fill and checksum are done.
// - Fill writes exactly one byte per clock cycle.
// - Random fill runs a shift register from the seed; a non-zero seed ends changed.
// - Zero seed in random fill yields only zero bytes.
// - Same seed gives the same random fill sequence.
// - Address fill stores the low address byte in each location.
// - Full address fill gives checksum f807 in both engines.
// - Pattern fill writes seed first, then rotates it left each address.
// - Pointers are 13 bits, low byte plus five high bits, rest read zero.
// - Both checksums are 16 bits, readable as low and high bytes.
package selftest_pkg;

    localparam int BUF_AW = 13;
    localparam logic [BUF_AW-1:0] BUF_TOP = 13'h1fff;
    localparam int PTR_HI_W = BUF_AW - 8;

    // Register indices on the plain register port
    localparam int REG_AW = 4;
    localparam logic [REG_AW-1:0] REG_MAIN_CTL = 4'h0;
    localparam logic [REG_AW-1:0] REG_RX_END_L = 4'h1;
    localparam logic [REG_AW-1:0] REG_RX_END_H = 4'h2;
    localparam logic [REG_AW-1:0] REG_DMA_ST_L = 4'h3;
    localparam logic [REG_AW-1:0] REG_DMA_ST_H = 4'h4;
    localparam logic [REG_AW-1:0] REG_DMA_END_L = 4'h5;
    localparam logic [REG_AW-1:0] REG_DMA_END_H = 4'h6;
    localparam logic [REG_AW-1:0] REG_DMA_CS_L = 4'h7;
    localparam logic [REG_AW-1:0] REG_DMA_CS_H = 4'h8;
    localparam logic [REG_AW-1:0] REG_SEED = 4'h9;
    localparam logic [REG_AW-1:0] REG_BST_CTL = 4'ha;
    localparam logic [REG_AW-1:0] REG_BST_CS_L = 4'hb;
    localparam logic [REG_AW-1:0] REG_BST_CS_H = 4'hc;

    // Main control fields
    localparam int MAIN_DMA_GO = 5;
    localparam int MAIN_CSUM_EN = 4;
    localparam int MAIN_TX_REQ = 3;
    localparam int MAIN_RX_EN = 2;

    // Self-test control fields
    localparam int CTL_GO = 0;
    localparam int CTL_TME = 1;
    localparam int CTL_MODE = 2;
    localparam int CTL_PSEL = 4;
    localparam int CTL_PSV = 5;

    // Reset values
    localparam logic [7:0] MAIN_CTL_RST = 8'h00;
    localparam logic [7:0] BST_CTL_RST = 8'h00;
    localparam logic [7:0] SEED_RST = 8'h00;
    localparam logic [BUF_AW-1:0] PTR_RST = 13'h0000;
    localparam logic [15:0] CSUM_RST = 16'h0000;

    // Feedback taps of the random fill generator
    localparam logic [7:0] LFSR_TAPS = 8'hb8;

    // One byte per clock: a full pass is buffer size times the period
    localparam int CLK_PERIOD_NS = 20;
    localparam int FILL_CYCLES = 1 << BUF_AW;

    typedef enum logic [1:0] {
        FILL_RANDOM = 2'b00,
        FILL_ADDRESS = 2'b01,
        FILL_PATTERN = 2'b10,
        FILL_RESERVED = 2'b11
    } fill_mode_t;

    typedef enum logic [1:0] {
        BIST_IDLE = 2'b01,
        BIST_FILL = 2'b10
    } bist_state_t;

    typedef enum logic [1:0] {
        DMA_IDLE = 2'b01,
        DMA_READ = 2'b10
    } dma_state_t;

    typedef struct packed {
        logic [BUF_AW-1:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } sram_req_t;

    typedef struct packed {
        logic [7:0] main_ctl;
        logic [BUF_AW-1:0] rx_end;
        logic [BUF_AW-1:0] dma_start;
        logic [BUF_AW-1:0] dma_end;
        logic [15:0] dma_csum;
        logic [15:0] bist_csum;
        logic [7:0] seed;
        logic [7:0] bst_ctl;
        bist_state_t bist_st;
        logic [BUF_AW-1:0] bist_addr;
        logic [15:0] bist_sum;
        dma_state_t dma_st;
        logic [BUF_AW-1:0] dma_addr;
        logic [15:0] dma_sum;
        logic dma_odd;
        logic cap;
        logic cap_odd;
        logic cap_last;
        logic cap_psel;
        sram_req_t port_a;
        sram_req_t port_b;
        logic [7:0] rdata;
    } state_t;

endpackage : selftest_pkg

// [logic/buffer_memory_self_test.sv]
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module buffer_memory_self_test
    import selftest_pkg::*;
(
    input logic CLK,
    input logic RST,
    input logic [REG_AW-1:0] ADDR,
    input logic [7:0] WDATA,
    input logic WR,
    input logic RD,
    output logic [7:0] RDATA,
    output sram_req_t PORT_A,
    input logic [7:0] PORT_A_RDATA,
    output sram_req_t PORT_B,
    input logic [7:0] PORT_B_RDATA
);

    state_t s;
    state_t next_s;
    sram_req_t bist_w;
    sram_req_t dma_r;
    logic [7:0] fill_data;
    logic [7:0] rd_byte;
    logic [15:0] sum_new;
    logic [2:0] psv;
    logic bist_cancel;
    logic dma_cancel;

    // Ones-complement add with end-around carry, even byte high
    function automatic logic [15:0] csum_add(
        input logic [15:0] sum,
        input logic [7:0] b,
        input logic odd
    );
        logic [15:0] val;
        logic [16:0] wide;
        val = odd ? {8'h00, b} : {b, 8'h00};
        wide = {1'b0, sum} + {1'b0, val};
        return wide[15:0] + {15'h0000, wide[16]};
    endfunction : csum_add

    function automatic logic [7:0] rotl(
        input logic [7:0] v,
        input logic [2:0] n
    );
        logic [15:0] dbl;
        dbl = {v, v} << n;
        return dbl[15:8];
    endfunction : rotl

    always_comb
    begin
        next_s = s;
        next_s.rdata = 8'h00;
        next_s.port_a = '0;
        next_s.port_b = '0;
        next_s.cap = 1'b0;
        next_s.cap_last = 1'b0;
        bist_w = '0;
        dma_r = '0;
        fill_data = 8'h00;
        rd_byte = 8'h00;
        sum_new = 16'h0000;
        psv = s.bst_ctl[CTL_PSV +: 3];

        // Register writes
        if (WR)
        begin
            case (ADDR)
                REG_MAIN_CTL: next_s.main_ctl = WDATA;
                REG_RX_END_L: next_s.rx_end[7:0] = WDATA;
                REG_RX_END_H: next_s.rx_end[BUF_AW-1:8] = WDATA[PTR_HI_W-1:0];
                REG_DMA_ST_L: next_s.dma_start[7:0] = WDATA;
                REG_DMA_ST_H: next_s.dma_start[BUF_AW-1:8] = WDATA[PTR_HI_W-1:0];
                REG_DMA_END_L: next_s.dma_end[7:0] = WDATA;
                REG_DMA_END_H: next_s.dma_end[BUF_AW-1:8] = WDATA[PTR_HI_W-1:0];
                REG_SEED:
                begin
                    // Fill engine owns the seed while it runs
                    if (s.bist_st == BIST_IDLE)
                    begin
                        next_s.seed = WDATA;
                    end
                end
                REG_BST_CTL: next_s.bst_ctl = WDATA;
                default: ;
            endcase
        end

        // Register reads, answered in the next cycle
        if (RD)
        begin
            case (ADDR)
                REG_MAIN_CTL: next_s.rdata = s.main_ctl;
                REG_RX_END_L: next_s.rdata = s.rx_end[7:0];
                REG_RX_END_H: next_s.rdata = {3'b000, s.rx_end[BUF_AW-1:8]};
                REG_DMA_ST_L: next_s.rdata = s.dma_start[7:0];
                REG_DMA_ST_H: next_s.rdata = {3'b000, s.dma_start[BUF_AW-1:8]};
                REG_DMA_END_L: next_s.rdata = s.dma_end[7:0];
                REG_DMA_END_H: next_s.rdata = {3'b000, s.dma_end[BUF_AW-1:8]};
                REG_DMA_CS_L: next_s.rdata = s.dma_csum[7:0];
                REG_DMA_CS_H: next_s.rdata = s.dma_csum[15:8];
                REG_SEED: next_s.rdata = s.seed;
                REG_BST_CTL: next_s.rdata = s.bst_ctl;
                REG_BST_CS_L: next_s.rdata = s.bist_csum[7:0];
                REG_BST_CS_H: next_s.rdata = s.bist_csum[15:8];
                default: next_s.rdata = 8'h00;
            endcase
        end

        // Go is only honoured with test mode enabled
        if (!next_s.bst_ctl[CTL_TME])
        begin
            next_s.bst_ctl[CTL_GO] = 1'b0;
        end
        bist_cancel = !next_s.bst_ctl[CTL_GO];

        // Fill engine
        unique case (s.bist_st)
            BIST_IDLE:
            begin
                if (next_s.bst_ctl[CTL_GO] && !s.bst_ctl[CTL_GO])
                begin
                    next_s.bist_st = BIST_FILL;
                    next_s.bist_addr = '0;
                    next_s.bist_sum = 16'h0000;
                end
            end
            BIST_FILL:
            begin
                if (bist_cancel)
                begin
                    next_s.bist_st = BIST_IDLE;
                end
                else
                begin
                    unique case (fill_mode_t'(s.bst_ctl[CTL_MODE +: 2]))
                        FILL_RANDOM:
                        begin
                            // Seed register is the generator state
                            fill_data = s.seed;
                            next_s.seed = {s.seed[6:0], ^(s.seed & LFSR_TAPS)};
                        end
                        FILL_ADDRESS:
                        begin
                            fill_data = s.bist_addr[7:0];
                        end
                        FILL_PATTERN:
                        begin
                            fill_data = s.seed;
                            next_s.seed = rotl(s.seed, psv);
                        end
                        FILL_RESERVED:
                        begin
                            fill_data = 8'h00;
                        end
                    endcase
                    // One write per cycle
                    bist_w.addr = s.bist_addr;
                    bist_w.wdata = fill_data;
                    bist_w.we = 1'b1;
                    sum_new = csum_add(s.bist_sum, fill_data, s.bist_addr[0]);
                    next_s.bist_sum = sum_new;
                    next_s.bist_addr = s.bist_addr + 1'b1;
                    if (s.bist_addr == BUF_TOP)
                    begin
                        next_s.bist_st = BIST_IDLE;
                        next_s.bist_csum = ~sum_new;
                        next_s.bst_ctl[CTL_GO] = 1'b0;
                    end
                end
            end
        endcase

        // Checksum-only DMA reader
        if (next_s.main_ctl[MAIN_DMA_GO] && !s.main_ctl[MAIN_DMA_GO]
            && !next_s.main_ctl[MAIN_CSUM_EN])
        begin
            next_s.main_ctl[MAIN_DMA_GO] = 1'b0;
        end
        dma_cancel = !next_s.main_ctl[MAIN_DMA_GO];

        unique case (s.dma_st)
            DMA_IDLE:
            begin
                if (next_s.main_ctl[MAIN_DMA_GO] && !s.main_ctl[MAIN_DMA_GO])
                begin
                    next_s.dma_st = DMA_READ;
                    next_s.dma_addr = next_s.dma_start;
                    next_s.dma_sum = 16'h0000;
                    next_s.dma_odd = 1'b0;
                end
            end
            DMA_READ:
            begin
                if (dma_cancel)
                begin
                    next_s.dma_st = DMA_IDLE;
                end
                else
                begin
                    // One read per cycle, matching the fill rate
                    dma_r.addr = s.dma_addr;
                    dma_r.re = 1'b1;
                    next_s.dma_odd = ~s.dma_odd;
                    next_s.dma_addr = s.dma_addr + 1'b1;
                    if (s.dma_addr == s.dma_end)
                    begin
                        next_s.dma_st = DMA_IDLE;
                    end
                end
            end
        endcase

        // Request now on a port; sync SRAM data stands next cycle
        if (!dma_cancel && (s.port_a.re || s.port_b.re))
        begin
            next_s.cap = 1'b1;
            next_s.cap_odd = ~s.dma_odd;
            next_s.cap_psel = s.port_a.re;
            next_s.cap_last = (s.port_a.re ? s.port_a.addr : s.port_b.addr) == s.dma_end;
        end

        // Read data taken the cycle after the request stood
        if (s.cap && !dma_cancel)
        begin
            rd_byte = s.cap_psel ? PORT_A_RDATA : PORT_B_RDATA;
            next_s.dma_sum = csum_add(s.dma_sum, rd_byte, s.cap_odd);
            if (s.cap_last)
            begin
                next_s.dma_csum = ~csum_add(s.dma_sum, rd_byte, s.cap_odd);
                next_s.main_ctl[MAIN_DMA_GO] = 1'b0;
            end
        end

        // Port assignment
        if (s.bst_ctl[CTL_PSEL])
        begin
            next_s.port_a = dma_r;
            next_s.port_b = bist_w;
        end
        else
        begin
            next_s.port_a = bist_w;
            next_s.port_b = dma_r;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s <= '0;
            s.main_ctl <= MAIN_CTL_RST;
            s.bst_ctl <= BST_CTL_RST;
            s.seed <= SEED_RST;
            s.rx_end <= PTR_RST;
            s.dma_start <= PTR_RST;
            s.dma_end <= PTR_RST;
            s.dma_csum <= CSUM_RST;
            s.bist_csum <= CSUM_RST;
            s.bist_st <= BIST_IDLE;
            s.dma_st <= DMA_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign RDATA = s.rdata;
    assign PORT_A = s.port_a;
    assign PORT_B = s.port_b;

endmodule : buffer_memory_self_test

// [sim/selftest_monitor.sv]
`timescale 1ns/1ps
module selftest_monitor
    import selftest_pkg::*;
(
    input logic CLK,
    input logic RST,
    input logic [REG_AW-1:0] ADDR,
    input logic [7:0] WDATA,
    input logic WR,
    input logic RD,
    input logic [7:0] RDATA,
    input sram_req_t PORT_A,
    input sram_req_t PORT_B
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    read_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not idle");
    fill_step_a: assert property (PORT_A.we && $past(PORT_A.we)
        |-> PORT_A.addr == $past(PORT_A.addr) + 13'h1)
        else $error("port a write skipped");
    swap_step_a: assert property (PORT_B.we && $past(PORT_B.we)
        |-> PORT_B.addr == $past(PORT_B.addr) + 13'h1)
        else $error("port b write skipped");
    fill_start_a: assert property (WR && ADDR == REG_BST_CTL && WDATA[1:0] == 2'b11
        && !WDATA[CTL_PSEL] |-> ##2 PORT_A.we && PORT_A.addr == 13'h0)
        else $error("fill start on a late");
    swap_start_a: assert property (WR && ADDR == REG_BST_CTL && WDATA[1:0] == 2'b11
        && WDATA[CTL_PSEL] |-> ##2 PORT_B.we && PORT_B.addr == 13'h0)
        else $error("fill start on b late");
    dma_start_a: assert property (WR && ADDR == REG_MAIN_CTL && WDATA[MAIN_DMA_GO]
        && WDATA[MAIN_CSUM_EN] |-> ##2 (PORT_A.re || PORT_B.re))
        else $error("reader start late");
    dma_step_a: assert property (PORT_B.re && $past(PORT_B.re)
        |-> PORT_B.addr == $past(PORT_B.addr) + 13'h1)
        else $error("reader skipped");
    one_writer_a: assert property (!(PORT_A.we && PORT_B.we))
        else $error("both ports written");
    abort_stop_a: assert property (WR && ADDR == REG_BST_CTL && WDATA == 8'h00
        |-> ##2 (!PORT_A.we && !PORT_B.we) [*8])
        else $error("writes after abort");
endmodule : selftest_monitor

bind buffer_memory_self_test selftest_monitor mon (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PORT_A(PORT_A), .PORT_B(PORT_B));

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top
    import selftest_pkg::*;
;
    logic clk, rst, wstb, rstb;
    logic [REG_AW-1:0] addr;
    logic [7:0] wdata, rdata, ard, brd, v, sd;
    sram_req_t pa, pb;
    logic [7:0] mem [0:8191];
    logic [31:0] rs;
    int n_mismatch, comparisons, na, nb, i;

    buffer_memory_self_test dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wstb), .RD(rstb), .RDATA(rdata), .PORT_A(pa), .PORT_A_RDATA(ard),
        .PORT_B(pb), .PORT_B_RDATA(brd));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Sync SRAM; an idle read port shows the inverse of its last value
    always @(posedge clk)
    begin
        if (pa.we)
        begin
            mem[pa.addr] <= pa.wdata;
            na++;
        end
        if (pb.we)
        begin
            mem[pb.addr] <= pb.wdata;
            nb++;
        end
        ard <= pa.re ? mem[pa.addr] : ~ard;
        brd <= pb.re ? mem[pb.addr] : ~brd;
    end

    function logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    function logic [7:0] nxt(input logic [1:0] m, input logic [2:0] n, input logic [7:0] s);
        if (m == FILL_RANDOM)
            return {s[6:0], ^(s & LFSR_TAPS)};
        return (s << n) | (s >> (4'd8 - n));
    endfunction : nxt

    task close_out;
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task chk(input string what, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task reg_wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
    endtask : reg_wr

    task reg_rd(input logic [REG_AW-1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd

    task run(input logic [1:0] m, input logic p, input logic [2:0] n, input logic [7:0] seed);
        logic [7:0] s, e, lo, hi;
        logic [31:0] acc;
        int bad;
        reg_wr(REG_DMA_ST_L, 8'h00);
        reg_wr(REG_DMA_ST_H, 8'h00);
        reg_wr(REG_DMA_END_L, 8'hff);
        reg_wr(REG_DMA_END_H, 8'h1f);
        reg_wr(REG_RX_END_L, 8'hff);
        reg_wr(REG_RX_END_H, 8'h1f);
        reg_wr(REG_MAIN_CTL, 8'h10);
        reg_wr(REG_SEED, seed);
        na = 0;
        nb = 0;
        reg_wr(REG_BST_CTL, {n, p, m, 2'b11});
        reg_wr(REG_MAIN_CTL, 8'h30);
        v = 8'h20;
        // Only the main control is polled while filling
        for (i = 0; i < 6000 && v[MAIN_DMA_GO] !== 1'b0; i++)
            reg_rd(REG_MAIN_CTL, v);
        if (v[MAIN_DMA_GO] !== 1'b0)
        begin
            chk("dma done", 16'h0, 16'h1);
            close_out;
        end
        reg_rd(REG_BST_CTL, v);
        chk("go bit", 16'h0, {15'h0, v[CTL_GO]});
        s = seed;
        acc = 0;
        bad = 0;
        for (i = 0; i < 8192; i++)
        begin
            e = (m == FILL_ADDRESS) ? i[7:0] : s;
            s = nxt(m, n, s);
            acc += i[0] ? {24'h0, e} : {16'h0, e, 8'h00};
            if (mem[i] !== e)
                bad++;
        end
        acc = acc[15:0] + acc[31:16];
        acc = acc[15:0] + acc[31:16];
        if (m == FILL_ADDRESS)
            acc = 32'hffff07f8;
        chk("fill data", 16'h0, 16'(bad));
        chk("chosen port writes", 16'd8192, 16'(p ? nb : na));
        chk("other port writes", 16'd0, 16'(p ? na : nb));
        reg_rd(REG_BST_CS_L, lo);
        reg_rd(REG_BST_CS_H, hi);
        chk("selftest checksum", ~acc[15:0], {hi, lo});
        reg_rd(REG_DMA_CS_L, lo);
        reg_rd(REG_DMA_CS_H, hi);
        chk("dma checksum", ~acc[15:0], {hi, lo});
        if (m == FILL_RANDOM && seed != 8'h00)
        begin
            reg_rd(REG_SEED, v);
            chk("seed changed", 16'h1, {15'h0, v !== seed});
        end
    endtask : run

    initial
    begin
        rst = 1'b1;
        wstb = 1'b0;
        rstb = 1'b0;
        addr = '0;
        wdata = 8'h00;
        ard = 8'h00;
        brd = 8'h00;
        rs = 32'd91727;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++)
        begin
            reg_rd(4'(a), v);
            chk("reset value", 16'h0, {8'h0, v});
        end
        reg_wr(REG_DMA_ST_H, 8'hff);
        reg_rd(REG_DMA_ST_H, v);
        chk("pointer high", 16'h1f, {8'h0, v});
        reg_wr(4'hf, 8'h55);
        reg_rd(4'hf, v);
        chk("unmapped", 16'h0, {8'h0, v});
        rs = xs(rs);
        sd = rs[7:0] | 8'h01;
        run(FILL_ADDRESS, 1'b0, 3'd0, 8'h00);
        run(FILL_RANDOM, 1'b0, 3'd0, sd);
        run(FILL_RANDOM, 1'b1, 3'd0, sd);
        rs = xs(rs);
        run(FILL_PATTERN, 1'b1, rs[10:8], rs[23:16]);
        run(FILL_RANDOM, 1'b0, 3'd0, 8'h00);
        reg_wr(REG_MAIN_CTL, 8'h10);
        reg_wr(REG_BST_CTL, 8'h07);
        reg_wr(REG_MAIN_CTL, 8'h30);
        repeat (100) @(posedge clk);
        reg_wr(REG_BST_CTL, 8'h00);
        reg_wr(REG_MAIN_CTL, 8'h00);
        i = na;
        repeat (20) @(posedge clk);
        chk("writes after abort", 16'(i), 16'(na));
        reg_rd(REG_BST_CTL, v);
        chk("control after abort", 16'h0, {8'h0, v});
        close_out;
    end
endmodule : tb_top
